//--- rtl/host_biu_pkg.sv
// Constants, mode codes and state types of the host bus interface unit
package host_biu_pkg;

  // ==========================================================================
  // Bus widths
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int LO_W   = 8;
  localparam int HI_W   = ADDR_W - LO_W;

  // ==========================================================================
  // Strap codes of the host family selection
  localparam logic [2:0] BUS_STROBE_ASYNC = 3'h0;
  localparam logic [2:0] BUS_STROBE_MUX   = 3'h1;
  localparam logic [2:0] BUS_DIR_ASYNC    = 3'h2;
  localparam logic [2:0] BUS_DIR_FIXED    = 3'h3;

  // ==========================================================================
  // Internal chip-select decoder window (mux mode)
  localparam logic [ADDR_W-1:0] DEC_MASK  = 13'h1800;
  localparam logic [ADDR_W-1:0] DEC_MATCH = 13'h0000;

  // ==========================================================================
  // Clocking figures and RAM size
  localparam int OSC_FREQ_MHZ  = 12;
  localparam int WORK_FREQ_MHZ = 48;
  localparam int PLL_MULT      = WORK_FREQ_MHZ / OSC_FREQ_MHZ;
  localparam int RAM_BYTES     = 5632;

  // ==========================================================================
  // Synchroniser layout: index and idle level of each host control input
  localparam int SY_CS  = 0;
  localparam int SY_RD  = 1;
  localparam int SY_WR  = 2;
  localparam int SY_DS  = 3;
  localparam int SY_ALE = 4;
  localparam int SY_RW  = 5;
  localparam int SY_N   = 6;
  localparam logic [SY_N-1:0] SY_IDLE = 6'h27;

  // ==========================================================================
  // Reset values
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 13'h0000;
  localparam logic [2:0]        SEL_RST  = 3'h0;
  localparam logic [1:0]        DIV_RST  = 2'h0;

  // ==========================================================================
  // Access sequencer, Gray coded along idle, access, hold
  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_ACCESS = 2'h1,
    ST_HOLD   = 2'h3
  } biu_state_t;

endpackage

//--- rtl/bit_sync.sv
// Two-stage synchroniser bank for host control inputs
`timescale 1ns/1ps

module bit_sync
  #(parameter int                 WIDTH    = 1,
    parameter logic [WIDTH-1:0]   IDLE_VAL = '0)
  (
    input  wire logic             ref_clk_in,  // Work clock
    input  wire logic             resetn_in,   // Async reset, active low
    input  wire logic [WIDTH-1:0] async_in,    // Raw pin levels
    output logic      [WIDTH-1:0] sync_out     // Synchronised levels
  );

  logic [WIDTH-1:0] meta_ff;

  // ==========================================================================
  // One two-flop chain per bit
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      always_ff @(posedge ref_clk_in or negedge resetn_in)
      begin
        if (!resetn_in)
        begin
          meta_ff[g]  <= IDLE_VAL[g];
          sync_out[g] <= IDLE_VAL[g];
        end
        else
        begin
          meta_ff[g]  <= async_in[g];
          sync_out[g] <= meta_ff[g];
        end
      end
    end
  endgenerate

endmodule

//--- rtl/host_biu.sv
// Host processor bus interface unit with clock prescaler and core control
//
// Summary of operation
// R1 - Host sees an 8-bit data path and a 13-bit address input.
// R2 - Two host clock outputs: work clock divided by 2 and by 4.
// R3 - Each divided clock output has its own enable bit.
// R4 - With PLL in use the 48 MHz work clock comes from 12 MHz.
// R5 - PLL-enable pin high bypasses the PLL; the oscillator clocks directly.
// R6 - Host reads and writes reach the dual-port RAM and registers.
// R7 - Three strap pins pick signalling style and fixed or handshaked timing.
// R8 - Integrated-core mode uses internal low-address latch and chip decoder.
// R9 - Code 011: fixed direction-line cycles, no data-acknowledge handshake.
// R10 - Code 010: asynchronous direction-line cycles ended by data acknowledge.
// R11 - Direction-line modes disable the decoder; host drives chip select.
// R12 - Multiplexed hosts demultiplex low address externally in these modes.
// R13 - Fixed direction mode: host clock at most quarter of divided clock.
// R14 - Fixed direction mode: host clock at most a tenth of work clock.
// R15 - Fixed direction mode: host clocked from the divide-by-four output.
// R16 - Core-disable pin high holds the integrated core in reset.
// R17 - Word hosts byte-swap reads or leave address bit zero open.
// R18 - Core external interrupt zero belongs to the communication engine.
// R19 - Code 001: fixed multiplexed strobe cycles, ALE latch, internal decode.
// R20 - In the multiplexed strobe mode the chip-select pin is tied high.
// R21 - Code 000: asynchronous strobe cycles with ready, external chip select.
// R22 - Host strobes and chip select are synchronised before any access.
`timescale 1ns/1ps

module host_biu
  import host_biu_pkg::*;
  (
    input  wire logic              ref_clk_in,          // Work clock
    input  wire logic              resetn_in,           // Async reset, low
    // Straps and configuration pins
    input  wire logic [2:0]        host_bus_select_in,  // Host family strap
    input  wire logic              pll_enable_n_in,     // High: bypass PLL
    input  wire logic              core_disable_pin_in, // High: core in reset
    input  wire logic              div2_clk_en_in,      // Mode bit: div2 on
    input  wire logic              div4_clk_en_in,      // Mode bit: div4 on
    // Host bus pins
    input  wire logic [ADDR_W-1:0] host_addr_in,        // Address pins
    input  wire logic [DATA_W-1:0] host_data_in,        // Data pins, input
    output logic      [DATA_W-1:0] host_data_out,       // Data pins, output
    output logic                   host_data_oe_out,    // Data drive enable
    input  wire logic              chip_select_n_in,    // External select
    input  wire logic              read_strobe_n_in,    // Read strobe
    input  wire logic              write_strobe_n_in,   // Write strobe
    input  wire logic              addr_latch_in,       // Address latch pulse
    input  wire logic              data_strobe_in,      // Direction-mode E
    input  wire logic              rw_dir_in,           // High read, low write
    output logic                   ready_n_out,         // Ready, low = done
    output logic                   ready_oe_out,        // Ready drive enable
    output logic                   data_ack_n_out,      // Data ack, low = done
    output logic                   data_ack_oe_out,     // Data ack enable
    // Host clock outputs
    output logic                   host_clk_div2_out,   // Work clock / 2
    output logic                   host_clk_div4_out,   // Work clock / 4
    // Clock source and core control
    output logic                   pll_bypass_out,      // Oscillator direct
    output logic                   core_reset_out,      // Core held in reset
    input  wire logic              engine_irq_in,       // Engine interrupt
    output logic                   core_ext_irq_zero_out, // Core irq zero
    // Internal RAM and register port
    output logic                   mem_req_out,         // Access request
    output logic                   mem_we_out,          // Write access
    output logic      [ADDR_W-1:0] mem_addr_out,        // Byte address
    output logic      [DATA_W-1:0] mem_wdata_out,       // Write data
    input  wire logic [DATA_W-1:0] mem_rdata_in,        // Read data
    input  wire logic              mem_ack_in           // Access done pulse
  );

  // ==========================================================================
  // Mode decoding helpers
  function automatic logic dir_mode(input logic [2:0] sel);
    dir_mode = (sel == BUS_DIR_ASYNC) || (sel == BUS_DIR_FIXED);
  endfunction

  function automatic logic bus_mode(input logic [2:0] sel);
    bus_mode = (sel == BUS_STROBE_ASYNC) || (sel == BUS_STROBE_MUX) ||
               dir_mode(sel);
  endfunction

  // ==========================================================================
  // State record
  typedef struct packed {
    biu_state_t          state;
    logic                strap_ok;
    logic [2:0]          bus_sel;
    logic [LO_W-1:0]     lo_addr;
    logic [1:0]          div_cnt;
    logic                clk2;
    logic                clk4;
    logic                pll_byp;
    logic                core_rst;
    logic                irq0;
    logic                req;
    logic                we;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
    logic [DATA_W-1:0]   rdata;
    logic                d_oe;
    logic                rdy_n;
    logic                rdy_oe;
    logic                ack_n;
    logic                ack_oe;
  } biu_reg_t;

  localparam biu_reg_t REG_RST = '{
    state:    ST_IDLE,
    strap_ok: 1'b0,
    bus_sel:  SEL_RST,
    lo_addr:  DATA_RST,
    div_cnt:  DIV_RST,
    clk2:     1'b0,
    clk4:     1'b0,
    pll_byp:  1'b0,
    core_rst: 1'b1,
    irq0:     1'b0,
    req:      1'b0,
    we:       1'b0,
    addr:     ADDR_RST,
    wdata:    DATA_RST,
    rdata:    DATA_RST,
    d_oe:     1'b0,
    rdy_n:    1'b1,
    rdy_oe:   1'b0,
    ack_n:    1'b1,
    ack_oe:   1'b0
  };

  biu_reg_t          cur_ff;
  biu_reg_t          nxt_ff;
  logic [SY_N-1:0]   sy;
  logic [ADDR_W-1:0] full_addr;
  logic              selected;
  logic              cyc_act;
  logic              cyc_rd;
  logic              fixed_t;

  // ==========================================================================
  // Host control inputs into the work clock domain
  bit_sync #(.WIDTH(SY_N), .IDLE_VAL(SY_IDLE)) u_sync (
    .ref_clk_in (ref_clk_in),
    .resetn_in  (resetn_in),
    .async_in   ({rw_dir_in, addr_latch_in, data_strobe_in,
                  write_strobe_n_in, read_strobe_n_in, chip_select_n_in}),
    .sync_out   (sy)                                              // R22
  );

  // ==========================================================================
  // Cycle qualification per strapped host family
  always_comb
  begin
    fixed_t   = (cur_ff.bus_sel == BUS_STROBE_MUX) ||
                (cur_ff.bus_sel == BUS_DIR_FIXED);
    full_addr = host_addr_in;
    selected  = !sy[SY_CS];                                       // R11 R21
    cyc_rd    = !sy[SY_RD];
    cyc_act   = 1'b0;
    if (cur_ff.bus_sel == BUS_STROBE_MUX)
    begin
      // Low address from the latch, select from the internal decoder
      full_addr = {host_addr_in[ADDR_W-1:LO_W], cur_ff.lo_addr};  // R8 R19
      selected  = (full_addr & DEC_MASK) == DEC_MATCH;            // R8 R19
    end
    if (dir_mode(cur_ff.bus_sel))
    begin
      cyc_rd  = sy[SY_RW];                                        // R9 R10
      cyc_act = selected && sy[SY_DS];
    end
    else
    begin
      cyc_act = selected && (!sy[SY_RD] || !sy[SY_WR]);
    end
    cyc_act = cyc_act && cur_ff.strap_ok && bus_mode(cur_ff.bus_sel); // R7
  end

  // ==========================================================================
  // Next-state logic
  always_comb
  begin
    nxt_ff = cur_ff;

    // Straps caught once after reset release
    if (!cur_ff.strap_ok)
    begin
      nxt_ff.strap_ok = 1'b1;
      nxt_ff.bus_sel  = host_bus_select_in;                       // R7
    end

    // Prescaler: free counter, each output gated by its enable
    nxt_ff.div_cnt = cur_ff.div_cnt + 2'h1;
    nxt_ff.clk2    = div2_clk_en_in && !cur_ff.div_cnt[0];        // R2 R3
    nxt_ff.clk4    = div4_clk_en_in &&
                     (nxt_ff.div_cnt[1] ^ 1'b0);                  // R2 R3

    // Clock source, core reset and interrupt routing
    nxt_ff.pll_byp  = pll_enable_n_in;                            // R4 R5
    nxt_ff.core_rst = core_disable_pin_in;                        // R16
    nxt_ff.irq0     = engine_irq_in;                              // R18

    // Low address latch follows the bus while the latch pulse is high
    if (cur_ff.bus_sel == BUS_STROBE_MUX && sy[SY_ALE])
      nxt_ff.lo_addr = host_data_in;                              // R19

    // Access sequencer
    nxt_ff.req = 1'b0;
    case (cur_ff.state)
      ST_IDLE:
      begin
        nxt_ff.d_oe   = 1'b0;
        nxt_ff.rdy_n  = 1'b1;
        nxt_ff.ack_n  = 1'b1;
        nxt_ff.rdy_oe = 1'b0;
        nxt_ff.ack_oe = 1'b0;
        if (cyc_act)
        begin
          nxt_ff.state = ST_ACCESS;
          nxt_ff.req   = 1'b1;                                    // R6
          nxt_ff.we    = !cyc_rd;
          nxt_ff.addr  = full_addr;                               // R1
          nxt_ff.wdata = host_data_in;                            // R1
          // Handshake line driven, not yet done
          nxt_ff.rdy_oe = cur_ff.bus_sel == BUS_STROBE_ASYNC;     // R21
          nxt_ff.ack_oe = cur_ff.bus_sel == BUS_DIR_ASYNC;        // R10
        end
      end
      ST_ACCESS:
      begin
        if (mem_ack_in)
        begin
          nxt_ff.state = ST_HOLD;
          nxt_ff.rdata = mem_rdata_in;
          nxt_ff.d_oe  = !cur_ff.we;
          nxt_ff.rdy_n = !(cur_ff.bus_sel == BUS_STROBE_ASYNC);   // R21
          nxt_ff.ack_n = !(cur_ff.bus_sel == BUS_DIR_ASYNC);      // R10
        end
        else if (!cyc_act && !fixed_t)
        begin
          // Host gave up; keep waiting for the pending access quietly
          nxt_ff.rdy_oe = 1'b0;
          nxt_ff.ack_oe = 1'b0;
        end
      end
      ST_HOLD:
      begin
        // Fixed timing never drives a handshake line
        if (fixed_t)
        begin
          nxt_ff.rdy_oe = 1'b0;                                   // R9 R19
          nxt_ff.ack_oe = 1'b0;                                   // R9
        end
        if (!cyc_act)
        begin
          nxt_ff.state  = ST_IDLE;
          nxt_ff.d_oe   = 1'b0;
          nxt_ff.rdy_n  = 1'b1;
          nxt_ff.ack_n  = 1'b1;
          nxt_ff.rdy_oe = 1'b0;
          nxt_ff.ack_oe = 1'b0;
        end
      end
      default:
      begin
        nxt_ff = REG_RST;
      end
    endcase
  end

  // ==========================================================================
  // State register
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      cur_ff <= REG_RST;
    else
      cur_ff <= nxt_ff;
  end

  // ==========================================================================
  // Outputs straight from the state register
  assign host_data_out         = cur_ff.rdata;
  assign host_data_oe_out      = cur_ff.d_oe;
  assign ready_n_out           = cur_ff.rdy_n;
  assign ready_oe_out          = cur_ff.rdy_oe;
  assign data_ack_n_out        = cur_ff.ack_n;
  assign data_ack_oe_out       = cur_ff.ack_oe;
  assign host_clk_div2_out     = cur_ff.clk2;
  assign host_clk_div4_out     = cur_ff.clk4;
  assign pll_bypass_out        = cur_ff.pll_byp;
  assign core_reset_out        = cur_ff.core_rst;
  assign core_ext_irq_zero_out = cur_ff.irq0;
  assign mem_req_out           = cur_ff.req;
  assign mem_we_out            = cur_ff.we;
  assign mem_addr_out          = cur_ff.addr;
  assign mem_wdata_out         = cur_ff.wdata;

endmodule

//--- verif/host_biu_properties.sv
// Concurrent checks on the ports of the host bus interface unit
`timescale 1ns/1ps

module host_biu_properties
  import host_biu_pkg::*;
  (
    input wire logic              ref_clk_in,          // Work clock
    input wire logic              resetn_in,           // Reset, low
    input wire logic [2:0]        host_bus_select_in,  // Strap
    input wire logic              core_disable_pin_in, // Core off pin
    input wire logic              div2_clk_en_in,      // Div2 enable
    input wire logic              div4_clk_en_in,      // Div4 enable
    input wire logic              read_strobe_n_in,    // Read strobe
    input wire logic              write_strobe_n_in,   // Write strobe
    input wire logic              data_strobe_in,      // Direction E
    input wire logic              ready_n_out,         // Ready
    input wire logic              ready_oe_out,        // Ready enable
    input wire logic              data_ack_n_out,      // Data ack
    input wire logic              data_ack_oe_out,     // Ack enable
    input wire logic              host_clk_div2_out,   // Clock / 2
    input wire logic              host_clk_div4_out,   // Clock / 4
    input wire logic              core_reset_out,      // Core reset
    input wire logic              mem_req_out,         // Request
    input wire logic              mem_we_out,          // Write access
    input wire logic              mem_ack_in,          // Done pulse
    input wire logic [DATA_W-1:0] mem_rdata_in,        // Read data
    input wire logic [DATA_W-1:0] host_data_out,       // Host data
    input wire logic              host_data_oe_out     // Data enable
  );
  // ==========================================================================
  // Checks, all in the work clock domain
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);

  AST_CORE_HOLD: assert property (
      core_reset_out == $past(core_disable_pin_in))
    else $error("Core reset does not follow its pin");
  AST_DIV2_RUN: assert property (
      div2_clk_en_in[*3] |->
      host_clk_div2_out != $past(host_clk_div2_out))
    else $error("Divide by two clock not toggling");
  AST_DIV4_RUN: assert property (
      div4_clk_en_in[*6] |->
      host_clk_div4_out != $past(host_clk_div4_out, 2))
    else $error("Divide by four clock period wrong");
  AST_DIV_OFF: assert property (
      (!div2_clk_en_in)[*2] |-> !host_clk_div2_out)
    else $error("Disabled divide by two clock runs");
  AST_RDY_MODE: assert property (
      ready_oe_out |-> host_bus_select_in == BUS_STROBE_ASYNC)
    else $error("Ready driven outside its mode");
  AST_ACK_MODE: assert property (
      data_ack_oe_out |-> host_bus_select_in == BUS_DIR_ASYNC)
    else $error("Data ack driven outside its mode");
  AST_RDY_DONE: assert property (
      mem_ack_in && ready_oe_out |=> !ready_n_out)
    else $error("Ready late after access");
  AST_ACK_DONE: assert property (
      mem_ack_in && data_ack_oe_out |=> !data_ack_n_out)
    else $error("Data ack late after access");
  AST_REQ_SYNC: assert property (
      mem_req_out |->
      $past(!read_strobe_n_in || !write_strobe_n_in || data_strobe_in, 2))
    else $error("Request before strobe was synchronised");
  AST_RDATA: assert property (
      mem_ack_in && !mem_we_out |=>
      host_data_oe_out && host_data_out == $past(mem_rdata_in))
    else $error("Read data not returned to host");
endmodule

//--- verif/ram_side_model.sv
// Behavioural RAM and register side answering the interface unit
`timescale 1ns/1ps

module ram_side_model
  import host_biu_pkg::*;
  (
    input  wire logic              ref_clk_in,         // Work clock
    input  wire logic              slow_in,            // Answer late
    input  wire logic              req_in,             // Access request
    input  wire logic              we_in,              // Write access
    input  wire logic [ADDR_W-1:0] addr_in,            // Byte address
    input  wire logic [DATA_W-1:0] wdata_in,           // Write data
    output logic      [DATA_W-1:0] rdata_out = 8'h5A,  // Read data
    output logic                   ack_out = 1'b0      // Done pulse
  );
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  int                wait_cnt = -1;

  // ==========================================================================
  // Answer after one or five cycles; read data is garbage outside the ack
  always @(posedge ref_clk_in)
  begin
    ack_out <= 1'b0;
    rdata_out <= ~rdata_out;
    if (req_in)
      wait_cnt <= slow_in ? 4 : 0;
    else if (wait_cnt > 0)
      wait_cnt <= wait_cnt - 1;
    else if (wait_cnt == 0)
    begin
      ack_out <= 1'b1;
      wait_cnt <= -1;
      if (we_in)
        mem[addr_in] <= wdata_in;
      else
        rdata_out <= mem[addr_in];
    end
  end
endmodule

//--- verif/host_biu_tb.sv
// Self-checking bench of the host bus interface unit
`timescale 1ns/1ps

module host_biu_tb;
  import host_biu_pkg::*;

  logic ref_clk_in = 1'b0, resetn_in = 1'b0, pll_enable_n_in = 1'b0;
  logic core_disable_pin_in = 1'b1, engine_irq_in = 1'b0, slow = 1'b0;
  logic div2_clk_en_in = 1'b0, div4_clk_en_in = 1'b0, rw_dir_in = 1'b1;
  logic chip_select_n_in = 1'b1, read_strobe_n_in = 1'b1;
  logic write_strobe_n_in = 1'b1, addr_latch_in = 1'b0;
  logic data_strobe_in = 1'b0;
  logic [2:0] host_bus_select_in = 3'h0;
  logic [ADDR_W-1:0] host_addr_in = 13'h0000, mem_addr_out;
  logic [DATA_W-1:0] host_data_in = 8'h00, host_data_out, mem_wdata_out;
  logic [DATA_W-1:0] mem_rdata_in, rd;
  logic host_data_oe_out, ready_n_out, ready_oe_out, data_ack_n_out;
  logic data_ack_oe_out, host_clk_div2_out, host_clk_div4_out, hs;
  logic pll_bypass_out, core_reset_out, core_ext_irq_zero_out;
  logic mem_req_out, mem_we_out, mem_ack_in;
  int   fail_count = 0, cmp_count = 0, req_cnt = 0;

  host_biu u_host_biu (.*);

  ram_side_model u_ram_side_model (
    .ref_clk_in (ref_clk_in),
    .slow_in    (slow),
    .req_in     (mem_req_out),
    .we_in      (mem_we_out),
    .addr_in    (mem_addr_out),
    .wdata_in   (mem_wdata_out),
    .rdata_out  (mem_rdata_in),
    .ack_out    (mem_ack_in)
  );

  // ==========================================================================
  // Clock, request counter and watchdog
  always #2 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in)
    if (mem_req_out)
      req_cnt <= req_cnt + 1;
  initial
  begin
    #20000;
    fail_count++;
    report_and_stop();
  end

  // ==========================================================================
  // Shared tasks
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic do_reset(input logic [2:0] m);
    resetn_in = 1'b0;
    host_bus_select_in = m;
    tick(12);
    resetn_in = 1'b1;
    tick(3);
  endtask

  // One host cycle in the strapped style; waits for handshake or 15 cycles
  task automatic host_cyc(input logic we, input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] d, input logic cs);
    host_addr_in = a;
    host_data_in = d;
    rw_dir_in = !we;
    hs = 1'b0;
    if (host_bus_select_in == BUS_STROBE_MUX)
    begin
      host_data_in = a[7:0];
      addr_latch_in = 1'b1;
      tick(3);
      addr_latch_in = 1'b0;
      tick(3);
      host_data_in = d;
    end
    else
      chip_select_n_in = !cs;
    if (host_bus_select_in[1])
      data_strobe_in = 1'b1;
    else
    begin
      read_strobe_n_in = we;
      write_strobe_n_in = !we;
    end
    for (int n = 0; n < 15 && !hs; n++)
    begin
      tick(1);
      hs = (!ready_n_out && ready_oe_out) ||
           (!data_ack_n_out && data_ack_oe_out);
    end
    rd = host_data_out;
    chip_select_n_in = 1'b1;
    read_strobe_n_in = 1'b1;
    write_strobe_n_in = 1'b1;
    data_strobe_in = 1'b0;
    tick(5);
    chk("data drive released", host_data_oe_out, 1'b0);
  endtask

  // ==========================================================================
  // Tests
  initial
  begin
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] d;
    int n0, e2, e4;
    logic p2, p4;
    for (int m = 0; m < 4; m++)
    begin
      do_reset(3'(m));
      slow = m[0];
      a = 13'h07A0 + 13'(m);
      d = 8'hA5 ^ 8'(m);
      n0 = req_cnt;
      host_cyc(1'b1, a, d, 1'b1);
      chk("write address", mem_addr_out, a);
      chk("ram byte", u_ram_side_model.mem[a], d);
      chk("write handshake", hs, !m[0]);
      host_cyc(1'b0, a, 8'h00, 1'b1);
      chk("read data", rd, d);
      chk("read handshake", hs, !m[0]);
      host_cyc(1'b1, (m == 1) ? 13'h1805 : a, 8'h3C, 1'b0);
      chk("refused cycle", 16'(req_cnt - n0), 16'h0002);
      chk("ram kept", u_ram_side_model.mem[a], d);
      $display("Test mode %0d done", m);
    end
    do_reset(3'h4);
    n0 = req_cnt;
    host_cyc(1'b1, 13'h0010, 8'h11, 1'b1);
    chk("inactive code", 16'(req_cnt - n0), 16'h0000);
    $display("Test inactive code done");
    chk("core held", core_reset_out, 1'b1);
    chk("pll in use", pll_bypass_out, 1'b0);
    core_disable_pin_in = 1'b0;
    pll_enable_n_in = 1'b1;
    engine_irq_in = 1'b1;
    div2_clk_en_in = 1'b1;
    div4_clk_en_in = 1'b1;
    tick(4);
    chk("core reset", core_reset_out, 1'b0);
    chk("pll bypass", pll_bypass_out, 1'b1);
    chk("irq zero", core_ext_irq_zero_out, 1'b1);
    e2 = 0;
    e4 = 0;
    for (int i = 0; i < 16; i++)
    begin
      p2 = host_clk_div2_out;
      p4 = host_clk_div4_out;
      tick(1);
      e2 += int'(p2 !== host_clk_div2_out);
      e4 += int'(p4 !== host_clk_div4_out);
    end
    chk("div2 edges", 16'(e2), 16'h0010);
    chk("div4 edges", 16'(e4), 16'h0008);
    div2_clk_en_in = 1'b0;
    tick(3);
    chk("div2 off", host_clk_div2_out, 1'b0);
    div2_clk_en_in = 1'b1;
    div4_clk_en_in = 1'b0;
    tick(3);
    chk("div4 off", host_clk_div4_out, 1'b0);
    $display("Test clocks and pins done");
    report_and_stop();
  end
endmodule

bind host_biu host_biu_properties u_props (.*);
